// file: hw/cwd_config_decode.sv
// start-up configuration decoder for clocking and watchdog with apb access
`timescale 1ns/100ps
`default_nettype none
module cwd_config_decode (
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [cwd_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic      [31:0]               prdata,
  output logic                           pslverr,
  input  wire logic                      deviceSleep,
  input  wire logic                      wdtClearInstr,
  input  wire logic                      wdtWindowOpen,
  output logic                           cfgLoaded,
  output logic                           twoSpeedStartupEn,
  output logic                           lowPowerRcHighPower,
  output logic                           secOscCrystalEn,
  output logic                           secDigitalClockInSel,
  output logic      [2:0]                startupOscSelect,
  output logic      [4:0]                startupSrcOneHot,
  output logic                           startupPllEn,
  output logic                           startupDivEn,
  output logic                           clockSwitchEn,
  output logic                           failSafeMonEn,
  output logic                           secOscHighPower,
  output logic      [1:0]                primaryFreqRange,
  output logic                           primaryFreqReserved,
  output logic                           clockOutputEn,
  output logic                           primaryOscEn,
  output logic      [1:0]                primaryOscMode,
  output logic                           wdtEnable,
  output logic                           wdtWindowed,
  output logic      [2:0]                wdtPrescaleLog2,
  output logic      [15:0]               wdtPostscaleRatio,
  output logic                           wdtCounterClear,
  output logic                           wdtResetReq
);
  import cwd_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    cwd_state_e  st;
    logic [7:0]  selByte;
    logic [7:0]  oscByte;
    logic [7:0]  wdtByte;
    logic        swEn;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        loaded;
    logic        twoSpeed;
    logic        lpRcHigh;
    logic        secXtal;
    logic        secDigIn;
    logic [2:0]  startSel;
    logic [4:0]  srcHot;
    logic        pllEn;
    logic        divEn;
    logic        swchEn;
    logic        fsmEn;
    logic        secHigh;
    logic [1:0]  freq;
    logic        freqBad;
    logic        clkOut;
    logic        poscEn;
    logic [1:0]  pmd;
    logic        wdtOn;
    logic        windowed;
    logic [2:0]  preLog2;
    logic [15:0] postRatio;
    logic        clrPulse;
    logic        rstReq;
  } cwd_regs_s;

  cwd_regs_s r;
  cwd_regs_s n;

  logic       memWe;
  logic [1:0] memAddr;
  logic [7:0] memWdata;
  logic [7:0] memRdata;
  logic       access;
  logic       mapped;
  logic       isCfg;

  // ****************************************************************
  // decoding helpers
  // ****************************************************************
  // one-hot order: fast rc, low-power fast rc, low-power rc, secondary, primary
  function automatic logic [4:0] srcDecode(input logic [2:0] code);
    logic [4:0] hot;
    hot = 5'h00;
    case (code)
      SRC_FAST_RC,
      SRC_FAST_RC_PLL,
      SRC_FAST_RC_DIV: hot = 5'h10;                  // [RL4] [RL5]
      SRC_LP_FAST_DIV: hot = 5'h08;                  // [RL5]
      SRC_LOW_PWR_RC:  hot = 5'h04;                  // [RL5]
      SRC_SECONDARY:   hot = 5'h02;                  // [RL5]
      SRC_PRIMARY,
      SRC_PRIMARY_PLL: hot = 5'h01;                  // [RL4]
      default:         hot = 5'h00;
    endcase
    return hot;
  endfunction

  function automatic logic wdtDecide(input logic [1:0] hw,
                                     input logic       sw,
                                     input logic       sleep);
    logic on;
    on = 1'b0;
    case (hw)
      WEN_ALWAYS:   on = 1'b1;                       // [RL11]
      WEN_SOFTWARE: on = sw;                         // [RL12]
      WEN_ACTIVE:   on = !sleep;                     // [RL12]
      WEN_OFF:      on = 1'b0;                       // [RL11]
      default:      on = 1'b0;
    endcase
    return on;
  endfunction

  function automatic logic [7:0] implMask(input logic [1:0] idx);
    return (idx == IDX_OSC_SEL) ? OSC_SEL_MASK : 8'hff;
  endfunction

  // ****************************************************************
  // configuration store
  // ****************************************************************
  cwd_cfg_store #(
    .DEPTH  (3),
    .WIDTH  (8),
    .AW     (2),
    .INIT   (RST_CFG)
  ) u_store (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .wrEn    (memWe),
    .addr    (memAddr),
    .wrData  (memWdata),
    .rdData  (memRdata)
  );

  assign access = psel && penable;
  assign isCfg  = (paddr == OFF_OSC_SEL) || (paddr == OFF_OSC) || (paddr == OFF_WDT);
  assign mapped = isCfg || (paddr == OFF_STATUS) || (paddr == OFF_ACTIVE)
                  || (paddr == OFF_CTRL);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    n          = r;
    n.pready   = 1'b0;
    n.pslverr  = 1'b0;
    n.clrPulse = 1'b0;
    n.rstReq   = 1'b0;
    memWe      = 1'b0;
    memAddr    = paddr[3:2];
    memWdata   = pwdata[7:0] & implMask(paddr[3:2]);       // [RL16]
    case (r.st)
      // the store is read back one byte per cycle after reset is released
      ST_LOAD0:
      begin
        memAddr = IDX_OSC_SEL;
        n.st    = ST_LOAD1;
      end
      ST_LOAD1:
      begin
        memAddr   = IDX_OSC;
        n.selByte = memRdata & OSC_SEL_MASK;                // [RL16]
        n.st      = ST_LOAD2;
      end
      ST_LOAD2:
      begin
        memAddr   = IDX_WDT;
        n.oscByte = memRdata;
        n.st      = ST_LOAD3;
      end
      ST_LOAD3:
      begin
        n.wdtByte = memRdata;
        n.st      = ST_DECODE;
      end
      // decoded once; nothing below touches these fields again until reset
      ST_DECODE:
      begin
        n.loaded    = 1'b1;                                 // [RL17]
        n.twoSpeed  = r.selByte[B_TWO_SPEED];               // [RL1]
        n.lpRcHigh  = r.selByte[B_LOW_POWER_RC_OSC_PWR];                // [RL2]
        n.secXtal   = r.selByte[B_SEC_SRC];                 // [RL3]
        n.secDigIn  = !r.selByte[B_SEC_SRC];                // [RL3]
        n.startSel  = r.selByte[F_START_LSB +: 3];
        n.srcHot    = srcDecode(r.selByte[F_START_LSB +: 3]);
        n.pllEn     = (r.selByte[F_START_LSB +: 3] == SRC_FAST_RC_PLL)
                      || (r.selByte[F_START_LSB +: 3] == SRC_PRIMARY_PLL); // [RL4]
        n.divEn     = (r.selByte[F_START_LSB +: 3] == SRC_FAST_RC_PLL)
                      || (r.selByte[F_START_LSB +: 3] == SRC_LP_FAST_DIV)
                      || (r.selByte[F_START_LSB +: 3] == SRC_FAST_RC_DIV); // [RL5]
        n.swchEn    = !r.oscByte[F_CKSM_LSB + 1];           // [RL6]
        n.fsmEn     = (r.oscByte[F_CKSM_LSB +: 2] == CKSM_MON_ON); // [RL6]
        n.secHigh   = r.oscByte[B_SEC_PWR];                 // [RL7]
        n.freq      = r.oscByte[F_FREQ_LSB +: 2];           // [RL8]
        n.freqBad   = (r.oscByte[F_FREQ_LSB +: 2] == FREQ_RESERVED); // [RL8]
        n.pmd       = r.oscByte[F_PMD_LSB +: 2];            // [RL10]
        n.poscEn    = (r.oscByte[F_PMD_LSB +: 2] != PMD_OFF); // [RL10]
        n.clkOut    = r.oscByte[B_CLK_OUT]
                      && ((r.oscByte[F_PMD_LSB +: 2] == PMD_OFF)
                      || (r.oscByte[F_PMD_LSB +: 2] == PMD_EXT_CLK)); // [RL9]
        n.windowed  = !r.wdtByte[B_WIN_DIS];                // [RL13]
        n.preLog2   = r.wdtByte[B_PRESCALE] ? PRE_LOG2_LONG
                                            : PRE_LOG2_SHORT; // [RL14]
        n.postRatio = POST_UNIT << r.wdtByte[F_POST_LSB +: 4]; // [RL15]
        n.st        = ST_RUN;
      end
      ST_RUN:
      begin
        // the hardware field sits split over bits 7 and 5
        n.wdtOn = wdtDecide({r.wdtByte[B_WEN_HI], r.wdtByte[B_WEN_LO]},
                            r.swEn, deviceSleep);           // [RL11] [RL12]
        // a clear while the watchdog is off does nothing at all
        if (wdtClearInstr && wdtDecide({r.wdtByte[B_WEN_HI], r.wdtByte[B_WEN_LO]},
                                       r.swEn, deviceSleep))
        begin
          if (r.windowed && !wdtWindowOpen)
          begin
            n.rstReq = 1'b1;                                // [RL13]
          end
          else
          begin
            n.clrPulse = 1'b1;
          end
        end
        // one wait state: the store read data register needs a cycle
        if (access && !r.pready)
        begin
          n.pready  = 1'b1;
          n.pslverr = !mapped;
          n.prdata  = 32'h0000_0000;
          if (isCfg)
          begin
            n.prdata = {24'h00_0000, memRdata};             // [RL16]
          end
          else if (paddr == OFF_STATUS)
          begin
            n.prdata = {24'h00_0000, r.wdtOn, r.windowed, r.freqBad, r.clkOut,
                        r.fsmEn, r.swchEn, r.poscEn, r.loaded};
          end
          else if (paddr == OFF_ACTIVE)
          begin
            n.prdata = {8'h00, r.wdtByte, r.oscByte, r.selByte}; // [RL17]
          end
          else if (paddr == OFF_CTRL)
          begin
            n.prdata = {31'h0000_0000, r.swEn};
          end
        end
        // writes take effect only on the completing edge
        if (access && r.pready && pwrite)
        begin
          memWe = isCfg;
          if (paddr == OFF_CTRL)
          begin
            n.swEn = pwdata[0];
          end
        end
      end
      default:
      begin
        n.st = ST_LOAD0;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign pready               = r.pready;
  assign prdata               = r.prdata;
  assign pslverr              = r.pslverr;
  assign cfgLoaded            = r.loaded;
  assign twoSpeedStartupEn    = r.twoSpeed;
  assign lowPowerRcHighPower  = r.lpRcHigh;
  assign secOscCrystalEn      = r.secXtal;
  assign secDigitalClockInSel = r.secDigIn;
  assign startupOscSelect     = r.startSel;
  assign startupSrcOneHot     = r.srcHot;
  assign startupPllEn         = r.pllEn;
  assign startupDivEn         = r.divEn;
  assign clockSwitchEn        = r.swchEn;
  assign failSafeMonEn        = r.fsmEn;
  assign secOscHighPower      = r.secHigh;
  assign primaryFreqRange     = r.freq;
  assign primaryFreqReserved  = r.freqBad;
  assign clockOutputEn        = r.clkOut;
  assign primaryOscEn         = r.poscEn;
  assign primaryOscMode       = r.pmd;
  assign wdtEnable            = r.wdtOn;
  assign wdtWindowed          = r.windowed;
  assign wdtPrescaleLog2      = r.preLog2;
  assign wdtPostscaleRatio    = r.postRatio;
  assign wdtCounterClear      = r.clrPulse;
  assign wdtResetReq          = r.rstReq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  property heldInRun;
    $past(cfgLoaded) |-> $stable({twoSpeedStartupEn, startupSrcOneHot,
                                  primaryOscMode, wdtPostscaleRatio, wdtWindowed});
  endproperty

  a_held_after_load: assert property (heldInRun)    // [RL17]
    else $error("decoded configuration changed after load");
  a_load_time: assert property (!cfgLoaded && $past(sys_rst) |-> ##5 cfgLoaded) // [RL17]
    else $error("configuration not loaded five cycles after reset");
  a_clkout_gate: assert property (clockOutputEn |-> primaryOscMode inside {2'h3, 2'h0}) // [RL9]
    else $error("clock output enabled with crystal mode");
  a_posc_off: assert property (cfgLoaded |-> primaryOscEn == (primaryOscMode != 2'h3)) // [RL10]
    else $error("primary enable disagrees with mode");
  a_monitor_needs: assert property (failSafeMonEn |-> clockSwitchEn) // [RL6]
    else $error("monitor on while switching off");
  a_sec_pins: assert property (cfgLoaded |-> secOscCrystalEn != secDigitalClockInSel) // [RL3]
    else $error("secondary pin function ambiguous");
  a_src_onehot: assert property (cfgLoaded |-> $onehot(startupSrcOneHot)) // [RL4]
    else $error("start-up source not one-hot");
  a_lp_div_sel: assert property (cfgLoaded && startupOscSelect == 3'h6
                                 |-> startupSrcOneHot == 5'h08 && startupDivEn) // [RL5]
    else $error("low-power divided source decoded wrong");
  a_post_ratio: assert property (cfgLoaded |-> $onehot(wdtPostscaleRatio)) // [RL15]
    else $error("postscale ratio not a power of two");
  a_prescale: assert property (cfgLoaded |-> wdtPrescaleLog2 inside {3'h5, 3'h7}) // [RL14]
    else $error("prescale ratio not 32 or 128");
  a_off_no_reset: assert property (cfgLoaded && wdtClearInstr && !r.wdtByte[B_WEN_HI] // [RL13]
                                   && !r.wdtByte[B_WEN_LO] |=> !wdtResetReq && !wdtCounterClear)
    else $error("clear acted while hardware field off");
  a_clear_off: assert property (cfgLoaded && !n.wdtOn && !r.wdtOn
                                && r.st == ST_RUN && wdtClearInstr
                                && !wdtDecide({r.wdtByte[B_WEN_HI], r.wdtByte[B_WEN_LO]},
                                              r.swEn, deviceSleep)
                                |=> !wdtResetReq && !wdtCounterClear) // [RL13]
    else $error("clear acted while watchdog off");
  a_always_on: assert property (cfgLoaded && r.wdtByte[7] && r.wdtByte[5]
                                |=> wdtEnable) // [RL11]
    else $error("watchdog not on with hardware code 11");
  a_pready_one: assert property (pready |=> !pready)
    else $error("pready held more than one cycle");

  c_read_cycle: cover property (psel && penable && pready && !pwrite);
  c_write_cycle: cover property (psel && penable && pready && pwrite);
  c_window_reset: cover property (wdtResetReq);
  c_clear_ok: cover property (wdtCounterClear);
endmodule // cwd_config_decode
`default_nettype wire

// file: hw/cwd_pkg.sv
// constants and types shared by the clock and watchdog configuration decoder
// Contract
// (RL1) two-speed start-up runs when its bit is 1, disabled at 0
// (RL2) low-power RC: 1 high-power high-accuracy, 0 low-power low-accuracy
// (RL3) secondary source 1: crystal on both pins; 0: digital clock input pin
// (RL4) start-up select 000 fast RC, 001 fast RC PLL, 010 primary, 011 primary PLL
// (RL5) start-up select 100 secondary, 101 LP RC, 110 500 kHz LP RC div, 111 RC div
// (RL6) switch/monitor 1x both off, 01 switching only, 00 both on
// (RL7) secondary oscillator power: 1 high-power, 0 low-power
// (RL8) frequency range 11 >8 MHz, 10 mid, 01 <100 kHz; 00 reserved
// (RL9) clock output driven only when enabled and primary mode is 11 or 00
// (RL10) primary mode 11 off, 10 high-speed, 01 standard crystal, 00 external
// (RL11) watchdog hardware field 11 always on, 00 always off ignoring software
// (RL12) hardware field 10 software decides; 01 on only while not sleeping
// (RL13) window bit 1 standard, 0 windowed; clear while fully off never resets
// (RL14) prescaler 1 gives 1:128, 0 gives 1:32
// (RL15) postscale ratio is two to the power of the four-bit code
// (RL16) unimplemented configuration bits always read back zero
// (RL17) decoded outputs captured after reset and held for normal operation
package cwd_pkg;
  localparam int ADDR_W = 8;
  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_OSC_SEL = 8'h00;
  localparam logic [7:0] OFF_OSC     = 8'h04;
  localparam logic [7:0] OFF_WDT     = 8'h08;
  localparam logic [7:0] OFF_STATUS  = 8'h0c;
  localparam logic [7:0] OFF_ACTIVE  = 8'h10;
  localparam logic [7:0] OFF_CTRL    = 8'h14;
  localparam logic [1:0] IDX_OSC_SEL = 2'h0;
  localparam logic [1:0] IDX_OSC     = 2'h1;
  localparam logic [1:0] IDX_WDT     = 2'h2;
  // ****************************************************************
  // power-up values of the stored configuration bytes
  // ****************************************************************
  localparam logic [7:0]  RST_OSC_SEL  = 8'he1;
  localparam logic [7:0]  RST_OSC      = 8'h3b;
  localparam logic [7:0]  RST_WDT      = 8'hdf;
  localparam logic [23:0] RST_CFG      = {RST_WDT, RST_OSC, RST_OSC_SEL};
  localparam logic [7:0]  OSC_SEL_MASK = 8'he7;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int B_TWO_SPEED = 7;
  localparam int B_LOW_POWER_RC_OSC_PWR  = 6;
  localparam int B_SEC_SRC   = 5;
  localparam int F_START_LSB = 0;
  localparam int F_CKSM_LSB  = 6;
  localparam int B_SEC_PWR   = 5;
  localparam int F_FREQ_LSB  = 3;
  localparam int B_CLK_OUT   = 2;
  localparam int F_PMD_LSB   = 0;
  localparam int B_WEN_HI    = 7;
  localparam int B_WIN_DIS   = 6;
  localparam int B_WEN_LO    = 5;
  localparam int B_PRESCALE  = 4;
  localparam int F_POST_LSB  = 0;
  // ****************************************************************
  // field codes
  // ****************************************************************
  localparam logic [2:0] SRC_FAST_RC     = 3'h0;
  localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRIMARY     = 3'h2;
  localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] SRC_SECONDARY   = 3'h4;
  localparam logic [2:0] SRC_LOW_PWR_RC  = 3'h5;
  localparam logic [2:0] SRC_LP_FAST_DIV = 3'h6;
  localparam logic [2:0] SRC_FAST_RC_DIV = 3'h7;
  localparam logic [1:0] PMD_OFF         = 2'h3;
  localparam logic [1:0] PMD_EXT_CLK     = 2'h0;
  localparam logic [1:0] FREQ_RESERVED   = 2'h0;
  localparam logic [1:0] CKSM_MON_ON     = 2'h0;
  localparam logic [1:0] WEN_ALWAYS      = 2'h3;
  localparam logic [1:0] WEN_SOFTWARE    = 2'h2;
  localparam logic [1:0] WEN_ACTIVE      = 2'h1;
  localparam logic [1:0] WEN_OFF         = 2'h0;
  localparam logic [2:0] PRE_LOG2_LONG   = 3'h7;
  localparam logic [2:0] PRE_LOG2_SHORT  = 3'h5;
  localparam logic [15:0] POST_UNIT      = 16'h0001;
  typedef enum logic [2:0] {
    ST_LOAD0  = 3'b000,
    ST_LOAD1  = 3'b001,
    ST_LOAD2  = 3'b010,
    ST_LOAD3  = 3'b011,
    ST_DECODE = 3'b100,
    ST_RUN    = 3'b101
  } cwd_state_e;
endpackage

// file: hw/cwd_cfg_store.sv
// small register-read store that holds the programmed configuration bytes
`timescale 1ns/100ps
`default_nettype none
module cwd_cfg_store #(
  parameter int               DEPTH = 3,
  parameter int               WIDTH = 8,
  parameter int               AW    = 2,
  parameter logic [DEPTH*WIDTH-1:0] INIT = '0
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    addr,
  input  wire logic [WIDTH-1:0] wrData,
  output logic      [WIDTH-1:0] rdData
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rdata;
  } cwd_store_s;
  // power-up contents stand in for the factory-programmed bytes
  cwd_store_s r = {INIT, {WIDTH{1'b0}}};
  cwd_store_s n;
  always_comb
  begin
    n = r;
    n.rdata = '0;
    if (int'(addr) < DEPTH)
    begin
      n.rdata = r.mem[addr];
      if (wrEn)
      begin
        n.mem[addr] = wrData;
      end
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      // programmed bytes must survive reset so the next load decodes them
      r <= {r.mem, {WIDTH{1'b0}}};
    end
    else
    begin
      r <= n;
    end
  end
  assign rdData = r.rdata;
endmodule // cwd_cfg_store
`default_nettype wire

// file: verification/cwd_tb.sv
// self-checking bench for the clock and watchdog configuration decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import cwd_pkg::*;
  logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err, swEn;
  logic [7:0]  paddr, s, o, w, s0, o0, w0;
  logic [31:0] pwdata, prdata, rd, r, ex;
  logic        deviceSleep, wdtClearInstr, wdtWindowOpen, cfgLoaded, startupDivEn;
  logic        twoSpeedStartupEn, lowPowerRcHighPower, secOscCrystalEn, secDigitalClockInSel;
  logic        startupPllEn, clockSwitchEn, failSafeMonEn, secOscHighPower, primaryFreqReserved;
  logic        clockOutputEn, primaryOscEn, wdtEnable, wdtWindowed, wdtCounterClear, wdtResetReq;
  logic [2:0]  startupOscSelect, wdtPrescaleLog2;
  logic [4:0]  startupSrcOneHot;
  logic [1:0]  primaryFreqRange, primaryOscMode;
  logic [15:0] wdtPostscaleRatio;
  int          nTests, badCount, seed;
  wire  [31:0] gotSel = {19'h0, twoSpeedStartupEn, lowPowerRcHighPower, secOscCrystalEn,
                         secDigitalClockInSel, startupOscSelect, startupSrcOneHot, startupPllEn};
  wire  [31:0] gotOsc = {22'h0, clockSwitchEn, failSafeMonEn, secOscHighPower, primaryFreqRange,
                         primaryFreqReserved, clockOutputEn, primaryOscEn, primaryOscMode};
  wire  [31:0] gotWdt = {12'h0, wdtWindowed, wdtPrescaleLog2, wdtPostscaleRatio};

  cwd_config_decode i_cwd_config_decode (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .deviceSleep, .wdtClearInstr, .wdtWindowOpen,
    .cfgLoaded, .twoSpeedStartupEn, .lowPowerRcHighPower, .secOscCrystalEn,
    .secDigitalClockInSel, .startupOscSelect, .startupSrcOneHot, .startupPllEn, .startupDivEn,
    .clockSwitchEn, .failSafeMonEn, .secOscHighPower, .primaryFreqRange, .primaryFreqReserved,
    .clockOutputEn, .primaryOscEn, .primaryOscMode, .wdtEnable, .wdtWindowed, .wdtPrescaleLog2,
    .wdtPostscaleRatio, .wdtCounterClear, .wdtResetReq);

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // expectations and bus tasks
  // ****************************************************************
  function automatic logic [31:0] expSel(input logic [7:0] v);
    logic [4:0] h;
    case (v[2:0])
      3'h2, 3'h3: h = 5'h01;
      3'h4:       h = 5'h02;
      3'h5:       h = 5'h04;
      3'h6:       h = 5'h08;
      default:    h = 5'h10;
    endcase
    return {19'h0, v[7:5], ~v[5], v[2:0], h, ~v[2] & v[0]};
  endfunction

  function automatic logic [31:0] expOsc(input logic [7:0] v);
    return {22'h0, ~v[7], v[7:6] == 2'h0, v[5:3], v[4:3] == 2'h0,
            v[2] & (v[1:0] == 2'h3 || v[1:0] == 2'h0), v[1:0] != 2'h3, v[1:0]};
  endfunction

  function automatic logic [31:0] expWdt(input logic [7:0] v);
    return {12'h0, ~v[6], v[4] ? 3'h7 : 3'h5, 16'h1 << v[3:0]};
  endfunction

  function automatic logic expEn(input logic [7:0] v, input logic sw, input logic sl);
    return ({v[7], v[5]} == 2'h3) | ({v[7], v[5]} == 2'h2 & sw) | ({v[7], v[5]} == 2'h1 & ~sl);
  endfunction

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic stopTest;
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one idle edge first so psel is never dropped and raised in the same time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++)
      @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apbAnswer", {31'h0, pready}, 32'h1);
    if (k >= 20)
      stopTest();
  endtask

  task automatic restart;
    int k;
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 20 && cfgLoaded !== 1'b1; k++)
      @(posedge sys_clk);
    chk("loaded", {31'h0, cfgLoaded}, 32'h1);
    if (k >= 20)
      stopTest();
    chk("selGroup", gotSel, expSel(s0));
    chk("oscGroup", gotOsc, expOsc(o0));
    chk("wdtGroup", gotWdt, expWdt(w0));
    chk("divEn", {31'h0, startupDivEn}, {31'h0, (s0[2:0] inside {3'h1, 3'h6, 3'h7})});
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    {sys_rst, psel, penable, pwrite, deviceSleep, wdtClearInstr, wdtWindowOpen} = 7'h40;
    paddr = 8'h00;
    pwdata = 32'h0;
    nTests = 0;
    badCount = 0;
    seed = 32'h5024ba60;
    {w0, o0, s0} = RST_CFG;
    restart();
    for (int i = 0; i < 16; i++)
    begin
      r = $random(seed);
      {w, o, s} = r[23:0];
      // first passes walk every start-up code and every watchdog enable code
      if (i < 8)
        s[2:0] = i[2:0];
      if (i < 4)
        {w[7], w[5]} = i[1:0];
      apb(1'b1, OFF_OSC_SEL, {r[31:8], s});
      apb(1'b1, OFF_OSC, {24'h0, o});
      apb(1'b1, OFF_WDT, {24'h0, w});
      apb(1'b0, OFF_OSC_SEL, 32'h0);
      chk("selByte", rd, {24'h0, s & OSC_SEL_MASK});
      apb(1'b0, OFF_OSC, 32'h0);
      chk("oscByte", rd, {24'h0, o});
      apb(1'b0, OFF_WDT, 32'h0);
      chk("wdtByte", rd, {24'h0, w});
      apb(1'b1, OFF_ACTIVE, r);
      apb(1'b0, OFF_ACTIVE, 32'h0);
      chk("activeBytes", rd, {8'h0, w0, o0, s0});
      chk("heldOsc", gotOsc, expOsc(o0));
      apb(1'b0, 8'hfc, 32'h0);
      chk("unmapped", {err, rd[30:0]}, 32'h80000000);
      s0 = s & OSC_SEL_MASK;
      o0 = o;
      w0 = w;
      restart();
      swEn = r[24];
      apb(1'b1, OFF_CTRL, {31'h0, swEn});
      deviceSleep <= r[25];
      wdtWindowOpen <= r[26];
      repeat (3) @(posedge sys_clk);
      chk("wdtEnable", {31'h0, wdtEnable}, {31'h0, expEn(w0, swEn, r[25])});
      apb(1'b0, OFF_CTRL, 32'h0);
      chk("swEnable", rd, {31'h0, swEn});
      ex = expOsc(o0);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("status", rd, {24'h0, expEn(w0, swEn, r[25]), ~w0[6], ex[4], ex[3], ex[8], ex[9],
                         ex[2], 1'b1});
      wdtClearInstr <= 1'b1;
      @(posedge sys_clk);
      wdtClearInstr <= 1'b0;
      @(posedge sys_clk);
      ex = !expEn(w0, swEn, r[25]) ? 32'h0 : (~w0[6] & ~r[26]) ? 32'h1 : 32'h2;
      chk("clearAnswer", {30'h0, wdtCounterClear, wdtResetReq}, ex);
    end
    stopTest();
  end
endmodule // testbench
`default_nettype wire
